/* design/nv_cfg_bank.sv */
// Configuration bank: timeout/threshold, diagnostic and CRC reference registers,
// with decoded values for the watchdog, supply monitor and diagnostic sequencer.
// Assumes an AXI4-Lite master on ref_clk and a synchronous active-high reset.
// Operation
// R1: Timeout code decodes to eight fixed times.
// R2: Supply threshold is five plus code volts.
// R3: Current codes 0-14 give (4c+1)/64.
// R4: Code 15 uses each channel's own current.
// R5: Pulse width codes decode to listed times.
// R6: Reserved bit ignored; codes 11-15 mean 1 ms.
// R7: Keep CRC reference byte over configuration.
//
// Implementation choice: the AXI4-Lite interface to the registers.
module nv_cfg_bank (
  input  wire logic                         ref_clk,            // 200 MHz clock
  input  wire logic                         rst,                // Sync reset, high
  input  wire logic [nv_cfg_pkg::ADR_W-1:0] s_axi_awaddr,       // Write address
  input  wire logic                         s_axi_awvalid,      // Write address valid
  output logic                              s_axi_awready,      // Write address ready
  input  wire logic [31:0]                  s_axi_wdata,        // Write data
  input  wire logic [3:0]                   s_axi_wstrb,        // Write strobes
  input  wire logic                         s_axi_wvalid,       // Write data valid
  output logic                              s_axi_wready,       // Write data ready
  output logic      [1:0]                   s_axi_bresp,        // Write response
  output logic                              s_axi_bvalid,       // Write response valid
  input  wire logic                         s_axi_bready,       // Write response ready
  input  wire logic [nv_cfg_pkg::ADR_W-1:0] s_axi_araddr,       // Read address
  input  wire logic                         s_axi_arvalid,      // Read address valid
  output logic                              s_axi_arready,      // Read address ready
  output logic      [31:0]                  s_axi_rdata,        // Read data
  output logic      [1:0]                   s_axi_rresp,        // Read response
  output logic                              s_axi_rvalid,       // Read data valid
  input  wire logic                         s_axi_rready,       // Read data ready
  output logic      [nv_cfg_pkg::CYC_W-1:0] link_timeout_cycles,// Watchdog silence time
  output logic      [4:0]                   low_supply_volts,   // Supply threshold in V
  output logic      [5:0]                   test_current_num,   // Test current over 64
  output logic                              test_current_chan,  // Use channel current
  output logic      [nv_cfg_pkg::CYC_W-1:0] test_pulse_cycles,  // Diagnostic pulse time
  output logic      [7:0]                   nv_config_crc_ref   // Stored CRC reference
);

  // ==========================================================================
  // State
  typedef struct packed {
    logic [7:0]  timeout_cfg;
    logic [7:0]  diag_cfg;
    logic [7:0]  crc_ref;
    logic        aw_held;
    logic [nv_cfg_pkg::ADR_W-1:0] aw_addr;
    logic        w_held;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } state_type;

  state_type cur;
  state_type next_state;

  logic [2:0] link_silence_timeout_sel;
  logic [3:0] low_supply_threshold_sel;
  logic [3:0] ondemand_test_current_sel;
  logic [3:0] ondemand_pulse_width_sel;

  assign link_silence_timeout_sel  = cur.timeout_cfg[nv_cfg_pkg::TIMEOUT_LSB +:
                                                     nv_cfg_pkg::TIMEOUT_W];
  assign low_supply_threshold_sel  = cur.timeout_cfg[nv_cfg_pkg::THRESH_LSB +:
                                                     nv_cfg_pkg::THRESH_W];
  assign ondemand_test_current_sel = cur.diag_cfg[nv_cfg_pkg::CURRENT_LSB +:
                                                  nv_cfg_pkg::CURRENT_W];
  assign ondemand_pulse_width_sel  = cur.diag_cfg[nv_cfg_pkg::PULSE_LSB +:
                                                  nv_cfg_pkg::PULSE_W];

  // ==========================================================================
  // Bus handshakes
  assign s_axi_awready = !cur.aw_held && !cur.bvalid;
  assign s_axi_wready  = !cur.w_held && !cur.bvalid;
  assign s_axi_arready = !cur.rvalid;
  assign s_axi_bvalid  = cur.bvalid;
  assign s_axi_bresp   = cur.bresp;
  assign s_axi_rvalid  = cur.rvalid;
  assign s_axi_rdata   = cur.rdata;
  assign s_axi_rresp   = cur.rresp;

  // ==========================================================================
  // Next state
  always_comb begin
    logic        aw_ok;
    logic        w_ok;
    logic [nv_cfg_pkg::ADR_W-1:0] waddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        map_hit;
    aw_ok   = 1'b0;
    w_ok    = 1'b0;
    waddr   = '0;
    wdata   = 32'h0000_0000;
    wstrb   = 4'h0;
    map_hit = 1'b0;
    next_state = cur;

    if (s_axi_awvalid && s_axi_awready) begin
      next_state.aw_held = 1'b1;
      next_state.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_state.w_held = 1'b1;
      next_state.w_data = s_axi_wdata;
      next_state.w_strb = s_axi_wstrb;
    end
    aw_ok = next_state.aw_held;
    w_ok  = next_state.w_held;
    waddr = next_state.aw_addr;
    wdata = next_state.w_data;
    wstrb = next_state.w_strb;

    // Commit write once address and data are both in hand
    if (aw_ok && w_ok && !cur.bvalid) begin
      map_hit = 1'b1;
      case (waddr)
        nv_cfg_pkg::TIMEOUT_CFG_ADDR: begin
          if (wstrb[0]) begin
            next_state.timeout_cfg = wdata[7:0] & nv_cfg_pkg::TIMEOUT_CFG_MASK; // R6
          end
        end
        nv_cfg_pkg::DIAG_CFG_ADDR: begin
          if (wstrb[0]) begin
            next_state.diag_cfg = wdata[7:0];
          end
        end
        nv_cfg_pkg::CRC_REF_ADDR: begin
          if (wstrb[0]) begin
            next_state.crc_ref = wdata[7:0]; // R7
          end
        end
        nv_cfg_pkg::STATUS_ADDR: begin
          map_hit = 1'b1;
        end
        default: begin
          map_hit = 1'b0;
        end
      endcase
      next_state.aw_held = 1'b0;
      next_state.w_held  = 1'b0;
      next_state.bvalid  = 1'b1;
      next_state.bresp   = map_hit ? nv_cfg_pkg::RESP_OKAY : nv_cfg_pkg::RESP_SLVERR;
    end else if (cur.bvalid && s_axi_bready) begin
      next_state.bvalid = 1'b0;
    end

    // Read path
    if (s_axi_arvalid && s_axi_arready) begin
      next_state.rvalid = 1'b1;
      next_state.rresp  = nv_cfg_pkg::RESP_OKAY;
      case (s_axi_araddr)
        nv_cfg_pkg::TIMEOUT_CFG_ADDR: next_state.rdata = {24'h00_0000, cur.timeout_cfg};
        nv_cfg_pkg::DIAG_CFG_ADDR:    next_state.rdata = {24'h00_0000, cur.diag_cfg};
        nv_cfg_pkg::CRC_REF_ADDR:     next_state.rdata = {24'h00_0000, cur.crc_ref};
        nv_cfg_pkg::STATUS_ADDR:      next_state.rdata = {25'h000_0000, test_current_chan,
                                                          test_current_num};
        default: begin
          next_state.rdata = 32'h0000_0000;
          next_state.rresp = nv_cfg_pkg::RESP_SLVERR;
        end
      endcase
    end else if (cur.rvalid && s_axi_rready) begin
      next_state.rvalid = 1'b0;
    end
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cur             <= '0;
      cur.timeout_cfg <= nv_cfg_pkg::TIMEOUT_CFG_RESET;
      cur.diag_cfg    <= nv_cfg_pkg::DIAG_CFG_RESET;
      cur.crc_ref     <= nv_cfg_pkg::CRC_REF_RESET;
    end else begin
      cur <= next_state;
    end
  end

  assign nv_config_crc_ref = cur.crc_ref; // R7

  // ==========================================================================
  // Field decoders
  nv_cfg_timeout_dec u_timeout_dec (
    .timeout_sel     (link_silence_timeout_sel),
    .threshold_sel   (low_supply_threshold_sel),
    .timeout_cycles  (link_timeout_cycles),
    .threshold_volts (low_supply_volts)
  );

  nv_cfg_diag_dec u_diag_dec (
    .current_sel         (ondemand_test_current_sel),
    .pulse_sel           (ondemand_pulse_width_sel),
    .current_num         (test_current_num),
    .use_channel_current (test_current_chan),
    .pulse_cycles        (test_pulse_cycles)
  );

endmodule : nv_cfg_bank

/* design/nv_cfg_pkg.sv */
// Constants for the timeout, supply threshold and diagnostic configuration bank.
// Assumes a 200 MHz ref_clk and a 32-bit AXI4-Lite register port.
package nv_cfg_pkg;

  // ==========================================================================
  // Register indices; a register's byte address is four times its index
  localparam int               ADR_W            = 10;
  localparam logic [7:0]       TIMEOUT_CFG_IDX  = 8'hC8;
  localparam logic [7:0]       DIAG_CFG_IDX     = 8'hC9;
  localparam logic [7:0]       CRC_REF_IDX      = 8'hCC;
  localparam logic [7:0]       STATUS_IDX       = 8'hD0;
  localparam logic [ADR_W-1:0] TIMEOUT_CFG_ADDR = {TIMEOUT_CFG_IDX, 2'h0};
  localparam logic [ADR_W-1:0] DIAG_CFG_ADDR    = {DIAG_CFG_IDX, 2'h0};
  localparam logic [ADR_W-1:0] CRC_REF_ADDR     = {CRC_REF_IDX, 2'h0};
  localparam logic [ADR_W-1:0] STATUS_ADDR      = {STATUS_IDX, 2'h0};

  // ==========================================================================
  // Reset values and timeout register write mask
  localparam logic [7:0] TIMEOUT_CFG_RESET = 8'h03;
  localparam logic [7:0] DIAG_CFG_RESET    = 8'h00;
  localparam logic [7:0] CRC_REF_RESET     = 8'h00;
  localparam logic [7:0] TIMEOUT_CFG_MASK  = 8'h7F;

  // ==========================================================================
  // Field layout
  localparam int TIMEOUT_LSB = 4;
  localparam int TIMEOUT_W   = 3;
  localparam int THRESH_LSB  = 0;
  localparam int THRESH_W    = 4;
  localparam int CURRENT_LSB = 4;
  localparam int CURRENT_W   = 4;
  localparam int PULSE_LSB   = 0;
  localparam int PULSE_W     = 4;

  // ==========================================================================
  // Decode constants
  localparam logic [4:0] SUPPLY_BASE_V     = 5'h05;
  localparam logic [3:0] CURRENT_USE_CHAN  = 4'hF;
  localparam logic [5:0] CURRENT_STEP      = 6'h04;
  localparam logic [5:0] CURRENT_OFFSET    = 6'h01;
  localparam int         CURRENT_DENOM     = 64;
  localparam logic [3:0] PULSE_LAST_CODE   = 4'hA;

  // ==========================================================================
  // Times in ns and cycle counts at the clock rate
  localparam int CLK_PERIOD_NS = 5;
  localparam int CYC_W         = 24;
  function automatic logic [CYC_W-1:0] ns_to_cyc(input int ns);
    ns_to_cyc = CYC_W'(ns / CLK_PERIOD_NS);
  endfunction : ns_to_cyc

  localparam int TIMEOUT_NS [8] = '{1000000, 125000, 250000, 500000,
                                    1250000, 2500000, 5000000, 10000000};
  localparam int PULSE_NS [11] = '{100000, 20000, 30000, 50000, 80000, 150000,
                                   200000, 300000, 500000, 800000, 1000000};

  // ==========================================================================
  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : nv_cfg_pkg

/* design/nv_cfg_timeout_dec.sv */
// Decodes the link timeout and supply threshold fields.
// Assumes fields come from registers on the same clock.
module nv_cfg_timeout_dec (
  input  wire logic [2:0]                   timeout_sel,        // Link timeout code
  input  wire logic [3:0]                   threshold_sel,      // Supply threshold code
  output logic      [nv_cfg_pkg::CYC_W-1:0] timeout_cycles,     // Timeout in clocks
  output logic      [4:0]                   threshold_volts     // Threshold in volts
);

  always_comb begin
    timeout_cycles  = nv_cfg_pkg::ns_to_cyc(nv_cfg_pkg::TIMEOUT_NS[timeout_sel]); // R1
    threshold_volts = nv_cfg_pkg::SUPPLY_BASE_V + {1'b0, threshold_sel};           // R2
  end

endmodule : nv_cfg_timeout_dec

/* design/nv_cfg_diag_dec.sv */
// Decodes the on-demand diagnostic current and pulse width fields.
// Assumes fields come from registers on the same clock.
module nv_cfg_diag_dec (
  input  wire logic [3:0]                   current_sel,        // Test current code
  input  wire logic [3:0]                   pulse_sel,          // Pulse width code
  output logic      [5:0]                   current_num,        // Numerator over 64
  output logic                              use_channel_current,// Use channel setting
  output logic      [nv_cfg_pkg::CYC_W-1:0] pulse_cycles        // Pulse width in clocks
);

  always_comb begin
    use_channel_current = (current_sel == nv_cfg_pkg::CURRENT_USE_CHAN);            // R4
    current_num = use_channel_current ? 6'h00
                : 6'(current_sel * nv_cfg_pkg::CURRENT_STEP)
                  + nv_cfg_pkg::CURRENT_OFFSET;                                     // R3
    if (pulse_sel > nv_cfg_pkg::PULSE_LAST_CODE) begin
      pulse_cycles = nv_cfg_pkg::ns_to_cyc(
                       nv_cfg_pkg::PULSE_NS[nv_cfg_pkg::PULSE_LAST_CODE]);          // R6
    end else begin
      pulse_cycles = nv_cfg_pkg::ns_to_cyc(nv_cfg_pkg::PULSE_NS[pulse_sel]);        // R5
    end
  end

endmodule : nv_cfg_diag_dec

/* testbench/nv_cfg_bank_asserts.sv */
// Checker: decoded outputs follow writes to the configuration bank.
// Assumes the master offers AW and W together on nv_cfg_bank ports.
module nv_cfg_bank_asserts (
  input wire logic                         ref_clk,             // Clock
  input wire logic                         rst,                 // Sync reset
  input wire logic [nv_cfg_pkg::ADR_W-1:0] s_axi_awaddr,        // AW address
  input wire logic                         s_axi_awvalid,       // AW valid
  input wire logic                         s_axi_awready,       // AW ready
  input wire logic [31:0]                  s_axi_wdata,         // W data
  input wire logic [3:0]                   s_axi_wstrb,         // W strobes
  input wire logic                         s_axi_wvalid,        // W valid
  input wire logic                         s_axi_wready,        // W ready
  input wire logic [nv_cfg_pkg::CYC_W-1:0] link_timeout_cycles, // Timeout
  input wire logic [4:0]                   low_supply_volts,    // Threshold
  input wire logic [5:0]                   test_current_num,    // Current
  input wire logic                         test_current_chan,   // Channel current
  input wire logic [nv_cfg_pkg::CYC_W-1:0] test_pulse_cycles,   // Pulse
  input wire logic [7:0]                   nv_config_crc_ref    // CRC byte
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========
  // Write decode
  logic wr_go, wr_tmo, wr_diag, wr_crc;
  assign wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
                 && s_axi_wstrb[0];
  assign wr_tmo = wr_go && s_axi_awaddr == nv_cfg_pkg::TIMEOUT_CFG_ADDR;
  assign wr_diag = wr_go && s_axi_awaddr == nv_cfg_pkg::DIAG_CFG_ADDR;
  assign wr_crc = wr_go && s_axi_awaddr == nv_cfg_pkg::CRC_REF_ADDR;
  default clocking dc @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  // ==========
  // Assertions
  AST_TIMEOUT_DEC: assert property (wr_tmo |=>
    link_timeout_cycles == nv_cfg_pkg::TIMEOUT_NS[$past(s_axi_wdata[6:4])] / 5)
    else $error("timeout decode wrong");
  AST_SUPPLY_DEC: assert property (wr_tmo |=>
    low_supply_volts == 5'h05 + $past(s_axi_wdata[3:0])) else $error("threshold wrong");
  AST_CURRENT_DEC: assert property (wr_diag && s_axi_wdata[7:4] != 4'hF |=>
    test_current_num == {$past(s_axi_wdata[7:4]), 2'b01} && !test_current_chan)
    else $error("current fraction wrong");
  AST_CURRENT_FORM: assert property (!test_current_chan |->
    test_current_num[1:0] == 2'b01) else $error("current numerator not 4c+1");
  AST_CURRENT_CHAN: assert property (wr_diag && s_axi_wdata[7:4] == 4'hF |=>
    test_current_chan) else $error("channel current not selected");
  AST_PULSE_DEC: assert property (wr_diag && s_axi_wdata[3:0] <= 4'hA |=>
    test_pulse_cycles == nv_cfg_pkg::PULSE_NS[$past(s_axi_wdata[3:0])] / 5)
    else $error("pulse decode wrong");
  AST_PULSE_SAT: assert property (wr_diag && s_axi_wdata[3:0] > 4'hA |=>
    test_pulse_cycles == 24'h030D40) else $error("pulse code above 10 not 1 ms");
  AST_CRC_LOAD: assert property (wr_crc |=>
    nv_config_crc_ref == $past(s_axi_wdata[7:0])) else $error("crc byte not stored");
  COV_TMO: cover property (wr_tmo);
  COV_CHAN: cover property (wr_diag && s_axi_wdata[7:4] == 4'hF);
  COV_CRC: cover property (wr_crc);
endmodule : nv_cfg_bank_asserts

bind nv_cfg_bank nv_cfg_bank_asserts nv_cfg_bank_asserts_inst (.ref_clk, .rst,
  .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
  .s_axi_wvalid, .s_axi_wready, .link_timeout_cycles, .low_supply_volts,
  .test_current_num, .test_current_chan, .test_pulse_cycles, .nv_config_crc_ref);

/* testbench/host_axi_model.sv */
// Host side model: AXI4-Lite master with random response stalls.
// Assumes the bench seeds $urandom before the first transfer.
module host_axi_model (
  input  wire logic                         ref_clk,       // Clock
  output logic      [nv_cfg_pkg::ADR_W-1:0] s_axi_awaddr,  // AW address
  output logic                              s_axi_awvalid, // AW valid
  input  wire logic                         s_axi_awready, // AW ready
  output logic      [31:0]                  s_axi_wdata,   // W data
  output logic      [3:0]                   s_axi_wstrb,   // W strobes
  output logic                              s_axi_wvalid,  // W valid
  input  wire logic                         s_axi_wready,  // W ready
  input  wire logic [1:0]                   s_axi_bresp,   // B response
  input  wire logic                         s_axi_bvalid,  // B valid
  output logic                              s_axi_bready,  // B ready
  output logic      [nv_cfg_pkg::ADR_W-1:0] s_axi_araddr,  // AR address
  output logic                              s_axi_arvalid, // AR valid
  input  wire logic                         s_axi_arready, // AR ready
  input  wire logic [31:0]                  s_axi_rdata,   // R data
  input  wire logic [1:0]                   s_axi_rresp,   // R response
  input  wire logic                         s_axi_rvalid,  // R valid
  output logic                              s_axi_rready   // R ready
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end
  // ==========
  // Transfers; released payloads are inverted
  task automatic wr(input logic [nv_cfg_pkg::ADR_W-1:0] a, input logic [31:0] d,
                    input logic [3:0] s, output logic [1:0] resp);
    int n = $urandom_range(2, 0);
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~d;
      end
    end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
    repeat (n) @(posedge ref_clk);
    s_axi_bready <= 1'b1;
    do @(posedge ref_clk); while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [nv_cfg_pkg::ADR_W-1:0] a, output logic [31:0] d,
                    output logic [1:0] resp);
    int n = $urandom_range(2, 0);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge ref_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    s_axi_araddr <= ~a;
    repeat (n) @(posedge ref_clk);
    s_axi_rready <= 1'b1;
    do @(posedge ref_clk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
endmodule : host_axi_model

/* testbench/eeprom_diag_timeout_config_test.sv */
// Testbench for nv_cfg_bank: reset values, every timeout, current and pulse code, strobes, unmapped place.
// Assumes host_axi_model as bus master and the bound checker.
module eeprom_diag_timeout_config_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [nv_cfg_pkg::ADR_W-1:0] s_axi_awaddr, s_axi_araddr, a;
  logic [7:0] nv_config_crc_ref, t_reg, d_reg, c_reg, v;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_data;
  logic [3:0] s_axi_wstrb, s;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [nv_cfg_pkg::CYC_W-1:0] link_timeout_cycles, test_pulse_cycles;
  logic [4:0] low_supply_volts;
  logic [5:0] test_current_num;
  logic test_current_chan;
  int errors = 0, num_checks = 0, cycles = 0, k;
  nv_cfg_bank nv_cfg_bank_inst (.ref_clk, .rst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .link_timeout_cycles,
    .low_supply_volts, .test_current_num, .test_current_chan, .test_pulse_cycles,
    .nv_config_crc_ref);
  host_axi_model host_axi_model_inst (.ref_clk, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  always #2.5 ref_clk = ~ref_clk;
  // ==========
  // Expectations and checks
  function automatic logic [31:0] tmo(input logic [2:0] c);
    int t[8] = '{1000, 125, 250, 500, 1250, 2500, 5000, 10000};
    return 32'(t[c] * 200);
  endfunction : tmo
  function automatic logic [31:0] pw(input logic [3:0] c);
    int p[11] = '{100, 20, 30, 50, 80, 150, 200, 300, 500, 800, 1000};
    return 32'(p[c > 4'hA ? 4'hA : c] * 200);
  endfunction : pw
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic chk_cfg();
    chk(32'(link_timeout_cycles), tmo(t_reg[6:4]));
    chk(32'(low_supply_volts), 32'(t_reg[3:0]) + 5);
    chk(32'(test_current_chan), 32'(d_reg[7:4] == 4'hF));
    chk(32'(test_current_num), d_reg[7:4] == 4'hF ? 0 : 32'(d_reg[7:4]) * 4 + 1);
    chk(32'(test_pulse_cycles), pw(d_reg[3:0]));
    chk(32'(nv_config_crc_ref), 32'(c_reg));
  endtask : chk_cfg
  task automatic final_report();
    $display("checks=%0d errors=%0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : final_report
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      final_report();
    end
  end
  // ==========
  // Tests
  initial begin
    void'($urandom(22262));
    {t_reg, d_reg, c_reg} = {8'h03, 8'h00, 8'h00};
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      a = i > 3 ? nv_cfg_pkg::CRC_REF_ADDR
        : (i % 2 ? nv_cfg_pkg::DIAG_CFG_ADDR : nv_cfg_pkg::TIMEOUT_CFG_ADDR);
      host_axi_model_inst.rd(a, rd_data, resp);
      chk(rd_data, i > 3 ? 0 : (i % 2 ? 32'h00 : 32'h03));
    end
    chk_cfg();
    $display("reset test done");
    for (int i = 0; i < 24; i++) begin
      a = i < 8 ? nv_cfg_pkg::TIMEOUT_CFG_ADDR
        : (i < 24 ? nv_cfg_pkg::DIAG_CFG_ADDR : nv_cfg_pkg::CRC_REF_ADDR);
      v = 8'($urandom);
      if (i < 8) v[6:4] = 3'(i);
      if (i < 2) v[3:0] = {4{i[0]}};
      if (i >= 8) v = {4'(i - 8), 4'(23 - i)};
      host_axi_model_inst.wr(a, {24'($urandom), v}, 4'hF, resp);
      chk(32'(resp), 0);
      if (a == nv_cfg_pkg::TIMEOUT_CFG_ADDR) t_reg = v & 8'h7F;
      else d_reg = v;
      host_axi_model_inst.rd(a, rd_data, resp);
      chk(32'(resp), 0);
      chk(rd_data, {24'h0, a == nv_cfg_pkg::TIMEOUT_CFG_ADDR ? t_reg : d_reg});
      chk_cfg();
    end
    $display("code table test done");
    for (int i = 0; i < 16; i++) begin
      k = $urandom_range(2, 0);
      a = k == 0 ? nv_cfg_pkg::TIMEOUT_CFG_ADDR
        : (k == 1 ? nv_cfg_pkg::DIAG_CFG_ADDR : nv_cfg_pkg::CRC_REF_ADDR);
      v = 8'($urandom);
      s = i < 4 ? 4'h0 : 4'($urandom);
      host_axi_model_inst.wr(a, {24'h0, v}, s, resp);
      chk(32'(resp), 0);
      if (s[0] && a == nv_cfg_pkg::TIMEOUT_CFG_ADDR) t_reg = v & 8'h7F;
      if (s[0] && a == nv_cfg_pkg::DIAG_CFG_ADDR) d_reg = v;
      if (s[0] && a == nv_cfg_pkg::CRC_REF_ADDR) c_reg = v;
      chk_cfg();
    end
    $display("random strobe test done");
    host_axi_model_inst.wr(10'h040, 32'hFFFF_FFFF, 4'hF, resp);
    chk(32'(resp), 32'(nv_cfg_pkg::RESP_SLVERR));
    host_axi_model_inst.rd(10'h040, rd_data, resp);
    chk(32'(resp), 32'(nv_cfg_pkg::RESP_SLVERR));
    chk(rd_data, 0);
    chk_cfg();
    $display("unmapped test done");
    // Status word is read-only: a write leaves the bank untouched
    host_axi_model_inst.wr(nv_cfg_pkg::STATUS_ADDR, 32'hFFFF_FFFF, 4'hF, resp);
    chk(32'(resp), 0);
    host_axi_model_inst.rd(nv_cfg_pkg::STATUS_ADDR, rd_data, resp);
    chk(32'(resp), 0);
    chk(rd_data, {25'h0, d_reg[7:4] == 4'hF,
                  d_reg[7:4] == 4'hF ? 6'h00 : {d_reg[7:4], 2'h1}});
    chk_cfg();
    $display("status test done");
    // Reset in mid-run restores every field
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    {t_reg, d_reg, c_reg} = {8'h03, 8'h00, 8'h00};
    @(posedge ref_clk);
    chk_cfg();
    host_axi_model_inst.rd(nv_cfg_pkg::TIMEOUT_CFG_ADDR, rd_data, resp);
    chk(rd_data, 32'h03);
    $display("mid-run reset test done");
    final_report();
  end
endmodule : eeprom_diag_timeout_config_test
